// >>> rtl/acc_top.sv
`timescale 1ns/1ps
module acc_top #(
    parameter int DEC_BASE = acc_pkg::DEC_BASE_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output acc_pkg::acc_dac_t [acc_pkg::NUM_DAC-1:0] dac_cfg,
    input wire logic [acc_pkg::NUM_PIN-1:0] gpio_drive_en,
    output logic [acc_pkg::NUM_PIN-1:0] shared_3v3_pin_oe,
    output logic [acc_pkg::NUM_PIN-1:0] shared_3v3_pin_dac_sel,
    output logic adc_clk,
    output logic adc_enable,
    output logic [4:0] adc_input_select,
    input wire logic [acc_pkg::ADC_W-1:0] adc_raw_code
);
    acc_pkg::acc_apb_req_t req;
    acc_pkg::acc_state_t state_q, state_d;
    logic [3:0] walk_idx_q, walk_idx_d;
    logic free_q, setup_done_q, setup_done_d, err_q, err_d;
    logic [acc_pkg::NUM_DAC-1:0] dac_enable_mask_q, dac_enable_mask_d;
    logic [3:0] dac_select_index_q, dac_select_index_d;
    logic [acc_pkg::CODE_W-1:0] dac_new_code_q, dac_new_code_d;
    acc_pkg::acc_dac_t [acc_pkg::NUM_DAC-1:0] dac_q, dac_d;
    logic [acc_pkg::NUM_PIN-1:0] claim_q, claim_d;
    logic [acc_pkg::EXP_W-1:0] adc_decimation_exponent_q, adc_exp_d;
    logic adc_en_q, adc_en_d, adc_cfg_done_q, adc_cfg_done_d;
    logic [4:0] adc_sel_q, adc_sel_d;
    logic [2:0] div_q, div_d;
    logic adc_clk_q, adc_clk_d;
    logic [acc_pkg::CNT_W-1:0] cnt_q, cnt_d, conv_target;
    logic [acc_pkg::ADC_W-1:0] result_q, result_d, sync1_q, sync2_q;
    logic fresh_q, fresh_d;
    logic walking, access, wr_acc, mapped, stage_hit, conv_done, adc_tick;
    logic upd_wr, upd_ok, upd_bad, commit, sel_legal, restart;
    acc_pkg::acc_stage_t stage_rd, stage_wr;
    logic [3:0] mem_rd_addr;

    function automatic logic [3:0] stage_idx(input logic [7:0] a);
        logic [7:0] off;
        off = a - acc_pkg::OFS_STAGE_BASE;
        stage_idx = off[5:2];
    endfunction

    function automatic logic in_stage(input logic [7:0] a);
        in_stage = a >= acc_pkg::OFS_STAGE_BASE &&
                   a <= acc_pkg::OFS_STAGE_LAST && a[1:0] == 2'b00;
    endfunction

    assign req = '{addr: paddr, sel: psel, en: penable, wr: pwrite,
                   wdata: pwdata};
    assign walking = state_q == acc_pkg::ST_WALK;
    assign stage_hit = in_stage(req.addr);
    assign mapped = stage_hit || req.addr == acc_pkg::OFS_CTRL ||
                    req.addr == acc_pkg::OFS_DAC_ENABLE ||
                    req.addr == acc_pkg::OFS_DAC_UPDATE ||
                    req.addr == acc_pkg::OFS_ADC_CFG ||
                    req.addr == acc_pkg::OFS_ADC_SEL ||
                    req.addr == acc_pkg::OFS_ADC_RESULT;
    // stall during the load walk; free_q gives staged reads a cycle
    assign pready = req.sel && req.en && !walking && free_q;
    assign pslverr = pready && !mapped;
    assign access = pready && mapped;
    assign wr_acc = access && req.wr;

    assign commit = wr_acc && req.addr == acc_pkg::OFS_CTRL &&
                    req.wdata[acc_pkg::CTRL_COMMIT_BIT];
    assign upd_wr = wr_acc && req.addr == acc_pkg::OFS_DAC_UPDATE;
    // index beyond nine or no setup yet: the update is dropped
    assign upd_ok = upd_wr && setup_done_q &&
        req.wdata[acc_pkg::UPD_IDX_LSB +: 4] <= acc_pkg::LAST_DAC;
    assign upd_bad = upd_wr && !upd_ok;

    assign stage_wr = '{
        mid: req.wdata[acc_pkg::STG_MID_LSB +: 2],
        step: req.wdata[acc_pkg::STG_STEP_BIT],
        code: req.wdata[acc_pkg::STG_CODE_LSB +: acc_pkg::CODE_W]};
    assign mem_rd_addr = walking ? walk_idx_q : stage_idx(req.addr);

    acc_stage_mem u_stage (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(wr_acc && stage_hit),
        .wr_addr(stage_idx(req.addr)),
        .wr_data(stage_wr),
        .rd_addr(mem_rd_addr),
        .rd_data(stage_rd)
    );

    // control and dac group
    always_comb begin
        state_d = state_q;
        walk_idx_d = walk_idx_q;
        setup_done_d = setup_done_q;
        err_d = err_q;
        dac_enable_mask_d = dac_enable_mask_q;
        dac_select_index_d = dac_select_index_q;
        dac_new_code_d = dac_new_code_q;
        dac_d = dac_q;
        if (wr_acc && req.addr == acc_pkg::OFS_DAC_ENABLE) begin
            dac_enable_mask_d = req.wdata[acc_pkg::NUM_DAC-1:0];
        end
        // error flag: write one clears, a new fault wins
        if (wr_acc && req.addr == acc_pkg::OFS_CTRL &&
            req.wdata[acc_pkg::CTRL_ERR_BIT]) begin
            err_d = 1'b0;
        end
        if (upd_bad) begin
            err_d = 1'b1;
        end
        if (upd_wr) begin
            dac_select_index_d = req.wdata[acc_pkg::UPD_IDX_LSB +: 4];
            dac_new_code_d =
                req.wdata[acc_pkg::UPD_CODE_LSB +: acc_pkg::CODE_W];
        end
        if (upd_ok) begin
            // only ten bits are taken, so no code exceeds 1023
            dac_d[req.wdata[acc_pkg::UPD_IDX_LSB +: 4]].code =
                req.wdata[acc_pkg::UPD_CODE_LSB +: acc_pkg::CODE_W];
        end
        unique case (state_q)
            acc_pkg::ST_IDLE: begin
                if (commit) begin
                    state_d = acc_pkg::ST_WALK;
                    walk_idx_d = 4'h0;
                end
            end
            acc_pkg::ST_WALK: begin
                walk_idx_d = walk_idx_q + 4'h1;
                if (walk_idx_q != 4'h0) begin
                    dac_d[walk_idx_q - 4'h1].code = stage_rd.code;
                    dac_d[walk_idx_q - 4'h1].step = stage_rd.step;
                    dac_d[walk_idx_q - 4'h1].mid = stage_rd.mid;
                end
                if (walk_idx_q == acc_pkg::LAST_DAC + 4'h1) begin
                    state_d = acc_pkg::ST_IDLE;
                    setup_done_d = 1'b1;
                    for (int i = 0; i < acc_pkg::NUM_DAC; i++) begin
                        dac_d[i].en = dac_enable_mask_q[i];
                    end
                end
            end
        endcase
    end

    // an enabled dac claims its pin from the general output driver
    always_comb begin
        claim_d = '0;
        for (int i = 0; i < acc_pkg::NUM_DAC; i++) begin
            if (dac_q[i].en) begin
                claim_d[acc_dac_pin_w(i)] = 1'b1;
            end
        end
    end

    function automatic logic [3:0] acc_dac_pin_w(input int i);
        acc_dac_pin_w = acc_pkg::acc_dac_pin(i);
    endfunction

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= acc_pkg::ST_IDLE;
            walk_idx_q <= 4'h0;
            free_q <= 1'b0;
            setup_done_q <= 1'b0;
            err_q <= 1'b0;
            dac_enable_mask_q <= acc_pkg::RST_MASK;
            dac_select_index_q <= 4'h0;
            dac_new_code_q <= '0;
            dac_q <= '0;
            claim_q <= '0;
        end else begin
            state_q <= state_d;
            walk_idx_q <= walk_idx_d;
            free_q <= !walking;
            setup_done_q <= setup_done_d;
            err_q <= err_d;
            dac_enable_mask_q <= dac_enable_mask_d;
            dac_select_index_q <= dac_select_index_d;
            dac_new_code_q <= dac_new_code_d;
            dac_q <= dac_d;
            claim_q <= claim_d;
        end
    end

    assign dac_cfg = dac_q;
    assign shared_3v3_pin_dac_sel = claim_q;
    assign shared_3v3_pin_oe = gpio_drive_en & ~claim_q;

    // adc group
    assign sel_legal = req.wdata[4:0] <= acc_pkg::SEL_EXT_LAST ||
                       req.wdata[4:0] == acc_pkg::SEL_TEMP;
    assign adc_tick = div_q == 3'(acc_pkg::ADC_DIV - 1);
    assign conv_target = CNT_W_SHIFT(adc_decimation_exponent_q);
    assign conv_done = adc_en_q && adc_tick && cnt_q == conv_target - 1'b1;

    function automatic logic [acc_pkg::CNT_W-1:0] CNT_W_SHIFT(
        input logic [acc_pkg::EXP_W-1:0] e);
        CNT_W_SHIFT = acc_pkg::CNT_W'(DEC_BASE) << e;
    endfunction

    always_comb begin
        adc_exp_d = adc_decimation_exponent_q;
        adc_en_d = adc_en_q;
        adc_cfg_done_d = adc_cfg_done_q;
        adc_sel_d = adc_sel_q;
        restart = 1'b0;
        // divide by five: one adc period of 25 ns
        div_d = adc_tick ? 3'h0 : div_q + 3'h1;
        adc_clk_d = div_d < 3'(acc_pkg::ADC_DIV / 2);
        cnt_d = cnt_q;
        result_d = result_q;
        fresh_d = fresh_q;
        if (wr_acc && req.addr == acc_pkg::OFS_ADC_CFG) begin
            adc_exp_d = req.wdata[acc_pkg::ADC_EXP_LSB +: acc_pkg::EXP_W];
            adc_en_d = req.wdata[acc_pkg::ADC_EN_BIT];
            adc_cfg_done_d = 1'b1;
            restart = 1'b1;
        end
        // illegal select codes keep the previous input
        if (wr_acc && req.addr == acc_pkg::OFS_ADC_SEL && sel_legal) begin
            adc_sel_d = req.wdata[4:0];
            restart = 1'b1;
        end
        if (restart || !adc_en_q) begin
            cnt_d = '0;
        end else if (conv_done) begin
            cnt_d = '0;
        end else if (adc_tick) begin
            cnt_d = cnt_q + 1'b1;
        end
        if (restart) begin
            fresh_d = 1'b0;
        end else if (conv_done) begin
            result_d = sync2_q;
            fresh_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            adc_decimation_exponent_q <= acc_pkg::RST_EXP;
            adc_en_q <= 1'b0;
            adc_cfg_done_q <= 1'b0;
            adc_sel_q <= acc_pkg::RST_SEL;
            div_q <= 3'h0;
            adc_clk_q <= 1'b0;
            cnt_q <= '0;
            result_q <= '0;
            fresh_q <= 1'b0;
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            adc_decimation_exponent_q <= adc_exp_d;
            adc_en_q <= adc_en_d;
            adc_cfg_done_q <= adc_cfg_done_d;
            adc_sel_q <= adc_sel_d;
            div_q <= div_d;
            adc_clk_q <= adc_clk_d;
            cnt_q <= cnt_d;
            result_q <= result_d;
            fresh_q <= fresh_d;
            sync1_q <= adc_raw_code;
            sync2_q <= sync1_q;
        end
    end

    assign adc_clk = adc_clk_q;
    assign adc_enable = adc_en_q;
    assign adc_input_select = adc_sel_q;

    // register readback
    always_comb begin
        prdata = '0;
        if (stage_hit) begin
            prdata[acc_pkg::STG_CODE_LSB +: acc_pkg::CODE_W] = stage_rd.code;
            prdata[acc_pkg::STG_STEP_BIT] = stage_rd.step;
            prdata[acc_pkg::STG_MID_LSB +: 2] = stage_rd.mid;
        end else begin
            unique case (req.addr)
                acc_pkg::OFS_CTRL: begin
                    prdata[acc_pkg::CTRL_BUSY_BIT] = walking;
                    prdata[acc_pkg::CTRL_DONE_BIT] = setup_done_q;
                    prdata[acc_pkg::CTRL_ERR_BIT] = err_q;
                    prdata[acc_pkg::CTRL_ADC_DONE_BIT] = adc_cfg_done_q;
                end
                acc_pkg::OFS_DAC_ENABLE:
                    prdata[acc_pkg::NUM_DAC-1:0] = dac_enable_mask_q;
                acc_pkg::OFS_DAC_UPDATE: begin
                    prdata[acc_pkg::UPD_IDX_LSB +: 4] = dac_select_index_q;
                    prdata[acc_pkg::UPD_CODE_LSB +: acc_pkg::CODE_W] =
                        dac_new_code_q;
                end
                acc_pkg::OFS_ADC_CFG: begin
                    prdata[acc_pkg::ADC_EXP_LSB +: acc_pkg::EXP_W] =
                        adc_decimation_exponent_q;
                    prdata[acc_pkg::ADC_EN_BIT] = adc_en_q;
                end
                acc_pkg::OFS_ADC_SEL: prdata[4:0] = adc_sel_q;
                acc_pkg::OFS_ADC_RESULT: begin
                    prdata[acc_pkg::ADC_W-1:0] = result_q;
                    prdata[acc_pkg::RES_FRESH_BIT] = fresh_q;
                end
                default: prdata = '0;
            endcase
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    AST_WALK_LEN: assert property ($rose(walking) |->
        ##11 (!walking && setup_done_q))
        else $error("load walk not eleven cycles");
    AST_EN_MASK: assert property ($fell(walking) |->
        dac_q[0].en == dac_enable_mask_q[0] &&
        dac_q[9].en == dac_enable_mask_q[9])
        else $error("enables differ from mask");
    AST_UPD_CODE: assert property (upd_ok |=>
        dac_q[dac_select_index_q].code == dac_new_code_q)
        else $error("single update code wrong");
    AST_UPD_BAD: assert property (upd_bad |=> err_q &&
        $stable(dac_q)) else $error("bad update took effect");
    AST_PIN_MAP: assert property (dac_q[0].en && dac_q[4].en |=>
        claim_q[9] && claim_q[0])
        else $error("dac pin mapping wrong");
    AST_PIN_TRI: assert property (claim_q[9] |->
        !shared_3v3_pin_oe[9]) else $error("claimed pin driven");
    AST_ADC_TICK: assert property (adc_tick |=>
        !adc_tick [*4] ##1 adc_tick) else $error("adc tick period wrong");
    AST_RES_HOLD: assert property (!conv_done |=>
        $stable(result_q)) else $error("result changed mid conversion");
    AST_ADC_OFF: assert property (!adc_en_q |->
        !conv_done && cnt_q == '0) else $error("disabled adc converts");
    AST_SEL_LEGAL: assert property (adc_sel_q <= 5'h03 ||
        adc_sel_q == 5'h10) else $error("illegal input select");

    CV_COMMIT: cover property ($fell(walking));
    CV_UPDATE: cover property (upd_ok);
    CV_UPD_ERR: cover property (upd_bad);
    CV_CONV: cover property (conv_done);
endmodule

// >>> rtl/acc_pkg.sv
package acc_pkg;
    localparam int NUM_DAC = 10;
    localparam int NUM_PIN = 12;
    localparam int CODE_W = 10;
    localparam int ADC_W = 12;
    localparam int EXP_W = 3;
    localparam int CNT_W = 17;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DAC_ENABLE = 8'h04;
    localparam logic [7:0] OFS_DAC_UPDATE = 8'h08;
    localparam logic [7:0] OFS_ADC_CFG = 8'h0c;
    localparam logic [7:0] OFS_ADC_SEL = 8'h10;
    localparam logic [7:0] OFS_ADC_RESULT = 8'h14;
    localparam logic [7:0] OFS_STAGE_BASE = 8'h40;
    localparam logic [7:0] OFS_STAGE_LAST = 8'h64;

    // field positions
    localparam int CTRL_COMMIT_BIT = 0;
    localparam int CTRL_BUSY_BIT = 0;
    localparam int CTRL_DONE_BIT = 1;
    localparam int CTRL_ERR_BIT = 2;
    localparam int CTRL_ADC_DONE_BIT = 3;
    localparam int UPD_CODE_LSB = 0;
    localparam int UPD_IDX_LSB = 16;
    localparam int STG_CODE_LSB = 0;
    localparam int STG_STEP_BIT = 12;
    localparam int STG_MID_LSB = 16;
    localparam int ADC_EXP_LSB = 0;
    localparam int ADC_EN_BIT = 4;
    localparam int RES_FRESH_BIT = 16;

    // input select codes
    localparam logic [4:0] SEL_EXT_LAST = 5'h03;
    localparam logic [4:0] SEL_TEMP = 5'h10;

    // reset values
    localparam logic [NUM_DAC-1:0] RST_MASK = 10'h000;
    localparam logic [EXP_W-1:0] RST_EXP = 3'h0;
    localparam logic [4:0] RST_SEL = 5'h00;

    // timing: adc clock derived from the system clock
    localparam int SYS_PERIOD_NS = 5;
    localparam int ADC_PERIOD_NS = 25;
    localparam int ADC_DIV = ADC_PERIOD_NS / SYS_PERIOD_NS;
    localparam int DEC_BASE_CYC = 256;
    localparam logic [3:0] LAST_DAC = 4'h9;

    typedef struct packed {
        logic [1:0] mid;
        logic step;
        logic [CODE_W-1:0] code;
    } acc_stage_t;

    typedef struct packed {
        logic en;
        logic [1:0] mid;
        logic step;
        logic [CODE_W-1:0] code;
    } acc_dac_t;

    typedef struct packed {
        logic [7:0] addr;
        logic sel;
        logic en;
        logic wr;
        logic [31:0] wdata;
    } acc_apb_req_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WALK = 2'b10
    } acc_state_t;

    // shared 3.3 V pin carrying each dac
    function automatic logic [3:0] acc_dac_pin(input int i);
        unique case (i)
            0: acc_dac_pin = 4'h9;
            1: acc_dac_pin = 4'h7;
            2: acc_dac_pin = 4'h6;
            3: acc_dac_pin = 4'ha;
            4: acc_dac_pin = 4'h0;
            5: acc_dac_pin = 4'h1;
            6: acc_dac_pin = 4'h3;
            7: acc_dac_pin = 4'h4;
            8: acc_dac_pin = 4'h5;
            default: acc_dac_pin = 4'h8;
        endcase
    endfunction
endpackage

// >>> rtl/acc_stage_mem.sv
`timescale 1ns/1ps
module acc_stage_mem (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [3:0] wr_addr,
    input wire acc_pkg::acc_stage_t wr_data,
    input wire logic [3:0] rd_addr,
    output acc_pkg::acc_stage_t rd_data
);
    acc_pkg::acc_stage_t mem_q [acc_pkg::NUM_DAC];
    acc_pkg::acc_stage_t rd_d;

    always_comb begin
        rd_d = '0;
        if (rd_addr <= acc_pkg::LAST_DAC) begin
            rd_d = mem_q[rd_addr];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_data <= '0;
            for (int i = 0; i < acc_pkg::NUM_DAC; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            rd_data <= rd_d;
            if (wr_en && wr_addr <= acc_pkg::LAST_DAC) begin
                mem_q[wr_addr] <= wr_data;
            end
        end
    end
endmodule

// >>> tb/tb_aux_converter_control.sv
`timescale 1ns/1ps
module tb_aux_converter_control;
    typedef struct packed {
        logic en;
        logic [1:0] mid;
        logic step;
        logic [9:0] code;
        logic [3:0] pin;
    } acc_row_t;

    logic sys_clk;
    logic rst;
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    acc_pkg::acc_dac_t [acc_pkg::NUM_DAC-1:0] dac_cfg;
    logic [11:0] gpio_drive_en;
    logic [11:0] pin_oe;
    logic [11:0] pin_sel;
    logic adc_clk;
    logic adc_enable;
    logic [4:0] adc_input_select;
    logic [11:0] adc_raw_code;
    int fail_count;
    int compares;
    logic [31:0] rd;
    logic er;
    logic [9:0] mask;
    logic [11:0] sel_exp;
    logic prev;
    int n;
    // stage inputs beside the pin each dac claims when enabled
    acc_row_t rows [10] = '{
        '{1'b1, 2'h0, 1'b0, 10'h000, 4'h9},
        '{1'b0, 2'h1, 1'b1, 10'h3ff, 4'h7},
        '{1'b1, 2'h2, 1'b0, 10'h200, 4'h6},
        '{1'b1, 2'h3, 1'b1, 10'h155, 4'ha},
        '{1'b1, 2'h0, 1'b1, 10'h2aa, 4'h0},
        '{1'b1, 2'h1, 1'b0, 10'h001, 4'h1},
        '{1'b0, 2'h2, 1'b1, 10'h3fe, 4'h3},
        '{1'b1, 2'h3, 1'b0, 10'h0f0, 4'h4},
        '{1'b1, 2'h2, 1'b1, 10'h30c, 4'h5},
        '{1'b1, 2'h1, 1'b0, 10'h1ff, 4'h8}};

    acc_top #(.DEC_BASE(4)) u_acc_top (
        .sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dac_cfg(dac_cfg), .gpio_drive_en(gpio_drive_en),
        .shared_3v3_pin_oe(pin_oe), .shared_3v3_pin_dac_sel(pin_sel),
        .adc_clk(adc_clk), .adc_enable(adc_enable),
        .adc_input_select(adc_input_select), .adc_raw_code(adc_raw_code));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic end_sim;
        if (fail_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask

    // answer taken at the edge that samples pready, released right after
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // registers settle before the caller looks at outputs
        @(negedge sys_clk);
    endtask

    task automatic wait_fresh(input int lim);
        int t;
        t = 0;
        do begin
            apb(1'b0, acc_pkg::OFS_ADC_RESULT, 32'h0);
            t++;
        end while (rd[16] !== 1'b1 && t < lim);
    endtask

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        gpio_drive_en = 12'hf0f;
        adc_raw_code = 12'ha5c;
        fail_count = 0;
        compares = 0;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        chk({31'h0, |dac_cfg}, 32'h0);
        chk({20'h0, pin_oe}, {20'h0, gpio_drive_en});
        chk({31'h0, adc_enable}, 32'h0);
        apb(1'b0, acc_pkg::OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        // an update before the first setup must be dropped
        apb(1'b1, acc_pkg::OFS_DAC_UPDATE, 32'h0000_0155);
        apb(1'b0, acc_pkg::OFS_CTRL, 32'h0);
        chk(rd, 32'h4);
        apb(1'b1, acc_pkg::OFS_CTRL, 32'h4);
        sel_exp = 12'h000;
        for (int i = 0; i < 10; i++) begin
            apb(1'b1, acc_pkg::OFS_STAGE_BASE + 8'(4 * i),
                {14'h0, rows[i].mid, 3'h0, rows[i].step, 2'h0, rows[i].code});
            mask[i] = rows[i].en;
            sel_exp[rows[i].pin] = rows[i].en;
        end
        apb(1'b1, acc_pkg::OFS_DAC_ENABLE, {22'h0, mask});
        apb(1'b0, acc_pkg::OFS_STAGE_BASE + 8'hc, 32'h0);
        chk(rd, {14'h0, rows[3].mid, 3'h0, rows[3].step, 2'h0,
            rows[3].code});
        apb(1'b1, acc_pkg::OFS_CTRL, 32'h1);
        apb(1'b0, acc_pkg::OFS_CTRL, 32'h0);
        chk(rd, 32'h2);
        for (int i = 0; i < 10; i++) begin
            chk({18'h0, dac_cfg[i]}, {18'h0, rows[i].en, rows[i].mid,
                rows[i].step, rows[i].code});
        end
        chk({20'h0, pin_sel}, {20'h0, sel_exp});
        chk({20'h0, pin_oe}, {20'h0, gpio_drive_en & ~sel_exp});
        // index one past the last dac is refused
        apb(1'b1, acc_pkg::OFS_DAC_UPDATE, 32'h000a_0077);
        apb(1'b0, acc_pkg::OFS_CTRL, 32'h0);
        chk(rd, 32'h6);
        apb(1'b1, acc_pkg::OFS_CTRL, 32'h4);
        apb(1'b1, acc_pkg::OFS_DAC_UPDATE, 32'h0009_0123);
        chk({22'h0, dac_cfg[9].code}, 32'h123);
        chk({22'h0, dac_cfg[8].code}, 32'h30c);
        apb(1'b1, acc_pkg::OFS_ADC_CFG, 32'h10);
        chk({31'h0, adc_enable}, 32'h1);
        n = 0;
        prev = adc_clk;
        repeat (50) begin
            @(negedge sys_clk);
            if (adc_clk && !prev) n++;
            prev = adc_clk;
        end
        chk(32'(n), 32'd10);
        apb(1'b1, acc_pkg::OFS_ADC_SEL, 32'h3);
        chk({27'h0, adc_input_select}, 32'h3);
        wait_fresh(60);
        chk(rd, 32'h0001_0a5c);
        @(posedge sys_clk);
        adc_raw_code <= 12'h123;
        apb(1'b1, acc_pkg::OFS_ADC_SEL, 32'h10);
        chk({27'h0, adc_input_select}, 32'h10);
        apb(1'b0, acc_pkg::OFS_ADC_RESULT, 32'h0);
        chk(rd, 32'h0000_0a5c);
        // exponent 1 doubles the count, so no result yet at 30 cycles
        apb(1'b1, acc_pkg::OFS_ADC_CFG, 32'h11);
        repeat (30) @(posedge sys_clk);
        apb(1'b0, acc_pkg::OFS_ADC_RESULT, 32'h0);
        chk({31'h0, rd[16]}, 32'h0);
        wait_fresh(60);
        chk(rd, 32'h0001_0123);
        apb(1'b1, acc_pkg::OFS_ADC_SEL, 32'h5);
        chk({27'h0, adc_input_select}, 32'h10);
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, acc_pkg::OFS_ADC_SEL, 32'(k));
            chk({27'h0, adc_input_select}, 32'(k));
        end
        apb(1'b0, 8'h30, 32'h0);
        chk({er, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, acc_pkg::OFS_ADC_CFG, 32'h0);
        chk({31'h0, adc_enable}, 32'h0);
        // a second setup with no enables hands every pin back
        apb(1'b1, acc_pkg::OFS_DAC_ENABLE, 32'h0);
        apb(1'b1, acc_pkg::OFS_CTRL, 32'h1);
        apb(1'b0, acc_pkg::OFS_CTRL, 32'h0);
        chk({20'h0, pin_sel}, 32'h0);
        chk({20'h0, pin_oe}, {20'h0, gpio_drive_en});
        end_sim;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        end_sim;
    end
endmodule
